// >>> common/fmt_cfg.svh
// constants for the format unit command handler and its initiator
`ifndef FMT_CFG_SVH
`define FMT_CFG_SVH
`define FMT_PI_BYTES 16'h0008
`define FMT_PI_FILL 8'hff
`define FMT_SHORT_HDR_LEN 4'h4
`define FMT_LONG_HDR_LEN 4'h8
`define FMT_SEL_NONE 2'h0
`define FMT_SEL_BAD 2'h1
`define FMT_SEL_T1 2'h2
`define FMT_SEL_T2 2'h3
`define FMT_USAGE_ZERO 3'h0
`define FMT_USAGE_T3 3'h1
`define FMT_BIT_OPTV 7
`define FMT_BIT_DPRI 6
`define FMT_BIT_DCERT 5
`define FMT_BIT_STOP 4
`define FMT_BIT_PAT 3
`define FMT_BIT_EARLY 1
`define FMT_SK_NOT_READY 4'h2
`define FMT_SK_ILLEGAL 4'h5
`define FMT_ASC_IN_PROG 16'h0404
`define FMT_ASC_BAD_CDB 16'h2400
`define FMT_ASC_BAD_LIST 16'h2600
`endif

// >>> common/fmt_if.sv
// command, data-out and status link between initiator and target
`default_nettype none
interface fmt_if;
    import fmt_pkg::*;
    logic cmd_valid;
    opcode_e cmd_op;
    logic [2:0] cmd_init;
    logic cmd_list;
    logic cmd_long;
    logic [1:0] cmd_sel;
    logic [31:0] cmd_lba;
    logic dout_valid;
    logic [7:0] dout_data;
    logic dout_last;
    logic rsp_valid;
    status_e rsp_status;
    logic [3:0] rsp_key;
    logic [15:0] rsp_asc;
    logic [7:0] attn_mask;
    modport initiator (
        output cmd_valid, cmd_op, cmd_init, cmd_list, cmd_long, cmd_sel,
        output cmd_lba, dout_valid, dout_data, dout_last,
        input rsp_valid, rsp_status, rsp_key, rsp_asc, attn_mask
    );
    modport target (
        input cmd_valid, cmd_op, cmd_init, cmd_list, cmd_long, cmd_sel,
        input cmd_lba, dout_valid, dout_data, dout_last,
        output rsp_valid, rsp_status, rsp_key, rsp_asc, attn_mask
    );
endinterface : fmt_if
`default_nettype wire

// >>> common/fmt_pkg.sv
// types shared by both ends of the format command link
`default_nettype none
package fmt_pkg;
    typedef enum logic [2:0] {
        OP_OTHER, OP_SENSE, OP_INQUIRY, OP_FORMAT, OP_READ, OP_WRITE
    } opcode_e;
    typedef enum logic [2:0] {
        ST_GOOD, ST_CHECK, ST_BUSY, ST_FULL
    } status_e;
endpackage : fmt_pkg
`default_nettype wire

// >>> design/fmt_initiator.sv
// initiator end: issues commands and sends the format header
`include "fmt_cfg.svh"
`default_nettype none
module fmt_initiator
    import fmt_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // link
    fmt_if.initiator link,
    // user side
    input wire logic req_i,
    input wire opcode_e op_i,
    input wire logic [2:0] init_id_i,
    input wire logic list_i,
    input wire logic long_i,
    input wire logic [1:0] sel_i,
    input wire logic [2:0] usage_i,
    input wire logic [7:0] opts_i,
    input wire logic [31:0] lba_i,
    output logic busy_o,
    output logic done_o,
    output logic [2:0] status_o
);
    typedef enum logic [1:0] {I_IDLE, I_CMD, I_DATA, I_WAIT} istate_e;
    typedef struct packed {
        istate_e st;
        logic [3:0] idx;
        logic lng;
        logic list;
        logic [2:0] usage;
        logic [7:0] opts;
        logic cmd_valid;
        opcode_e op;
        logic [2:0] id;
        logic [1:0] sel;
        logic [31:0] lba;
        logic dv;
        logic [7:0] dd;
        logic dl;
        logic done;
        logic [2:0] stat;
    } ini_s;
    ini_s r, next_r;

    // header byte at an index, short or long form
    function automatic logic [7:0] hdr_byte(logic [3:0] i, logic lng,
                                            logic [2:0] u, logic [7:0] o);
        if (i == 4'h0) begin
            hdr_byte = {5'h00, u};
        end else if (i == 4'h1) begin
            hdr_byte = o;
        end else begin
            hdr_byte = 8'h00; // zero info, zero length
        end
    endfunction : hdr_byte

    // next-state logic
    always_comb begin
        logic [3:0] len;
        len = r.lng ? `FMT_LONG_HDR_LEN : `FMT_SHORT_HDR_LEN;
        next_r = r;
        next_r.cmd_valid = 1'b0;
        next_r.dv = 1'b0;
        next_r.dl = 1'b0;
        next_r.done = 1'b0;
        case (r.st)
            I_IDLE: begin
                if (req_i) begin
                    next_r.st = I_CMD;
                    next_r.cmd_valid = 1'b1;
                    next_r.op = op_i;
                    next_r.id = init_id_i;
                    next_r.list = list_i && (op_i == OP_FORMAT);
                    next_r.lng = long_i;
                    next_r.sel = sel_i;
                    next_r.usage = usage_i;
                    next_r.opts = opts_i;
                    next_r.lba = lba_i;
                    next_r.idx = 4'h0;
                end
            end
            I_CMD: begin
                next_r.st = r.list ? I_DATA : I_WAIT;
            end
            I_DATA: begin
                if (link.rsp_valid) begin
                    // refused at the command: drop the header, go idle
                    next_r.st = I_IDLE;
                    next_r.done = 1'b1;
                    next_r.stat = 3'(link.rsp_status);
                end else begin
                    next_r.dv = 1'b1;
                    next_r.dd = hdr_byte(r.idx, r.lng, r.usage, r.opts);
                    next_r.dl = (r.idx == len - 4'h1);
                    next_r.idx = r.idx + 4'h1;
                    if (r.idx == len - 4'h1) begin
                        next_r.st = I_WAIT;
                    end
                end
            end
            I_WAIT: begin
                if (link.rsp_valid) begin
                    next_r.st = I_IDLE; // answer received: latch status, pulse done, go idle
                    next_r.done = 1'b1;
                    next_r.stat = 3'(link.rsp_status);
                end
            end
            default: next_r.st = I_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // link and user outputs
    assign link.cmd_valid = r.cmd_valid;
    assign link.cmd_op = r.op;
    assign link.cmd_init = r.id;
    assign link.cmd_list = r.list;
    assign link.cmd_long = r.lng;
    assign link.cmd_sel = r.sel;
    assign link.cmd_lba = r.lba;
    assign link.dout_valid = r.dv;
    assign link.dout_data = r.dd;
    assign link.dout_last = r.dl;
    assign busy_o = (r.st != I_IDLE);
    assign done_o = r.done;
    assign status_o = r.stat;
endmodule : fmt_initiator
`default_nettype wire

// >>> design/fmt_target.sv
// target end: format command handling, gating and protection layout
`include "fmt_cfg.svh"
`default_nettype none
module fmt_target
    import fmt_pkg::*;
#(
    parameter int FMT_CYCLES = 64
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // link
    fmt_if.target link,
    // user side
    input wire logic queue_disable_flag_i,
    input wire logic [15:0] block_size_i,
    input wire logic fmt_abort_i,
    output logic fmt_active_o,
    output logic fmt_queued_o,
    output logic degraded_o,
    output logic protection_enabled_flag_o,
    output logic [1:0] prot_type_o,
    output logic [15:0] stored_block_o,
    output logic [7:0] pi_fill_o,
    output logic [31:0] ref_tag_o,
    output logic ref_tag_valid_o
);
    initial begin
        if (FMT_CYCLES < 1) $error("FMT_CYCLES must be positive");
    end

    typedef enum logic [2:0] {
        T_IDLE, T_HDR, T_QUEUED, T_RUN
    } tstate_e;

    typedef struct packed {
        tstate_e st;
        logic [3:0] hcnt;
        logic hlong;
        logic [1:0] sel;
        logic [2:0] usage;
        logic [7:0] opts;
        logic [2:0] owner;
        logic [31:0] lba;
        logic [31:0] cnt;
        logic degraded;
        logic protection_enabled_flag;
        logic [1:0] ptype;
        logic [15:0] stored;
        logic [31:0] ref_tag;
        logic ref_valid;
        logic rsp_valid;
        status_e rsp_status;
        logic [3:0] rsp_key;
        logic [15:0] rsp_asc;
        logic [7:0] attn;
    } tgt_s;

    tgt_s r, next_r;

    // answer helper
    function automatic tgt_s answer(tgt_s s, status_e st, logic [3:0] k,
                                    logic [15:0] a);
        s.rsp_valid = 1'b1;
        s.rsp_status = st;
        s.rsp_key = k;
        s.rsp_asc = a;
        return s;
    endfunction : answer

    // selector and usage decode: 0 ok type0, 1 t1, 2 t2, 3 bad list
    function automatic logic [1:0] decode(logic [1:0] sel, logic [2:0] u);
        if (sel == `FMT_SEL_NONE && u == `FMT_USAGE_ZERO) begin
            decode = 2'h0;
        end else if (sel == `FMT_SEL_T1 && u == `FMT_USAGE_ZERO) begin
            decode = 2'h1;
        end else if (sel == `FMT_SEL_T2 && u == `FMT_USAGE_ZERO) begin
            decode = 2'h2;
        end else begin
            decode = 2'h3;
        end
    endfunction : decode

    // next-state logic
    always_comb begin
        logic [1:0] d;
        logic busy;
        d = 2'h0;
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.ref_valid = 1'b0;
        busy = (r.st == T_RUN) || (r.st == T_QUEUED);
        // header capture during data-out
        if (r.st == T_HDR && link.dout_valid) begin
            next_r.hcnt = r.hcnt + 4'h1;
            if (r.hcnt == 4'h0) begin
                next_r.usage = link.dout_data[2:0];
            end
            if (r.hcnt == 4'h1) begin
                next_r.opts = link.dout_data;
            end
            if (link.dout_last) begin
                d = decode(r.sel, next_r.usage);
                if (d == 2'h3) begin
                    next_r.st = T_IDLE;
                    next_r = answer(next_r, ST_CHECK, `FMT_SK_ILLEGAL,
                                    `FMT_ASC_BAD_LIST);
                end else begin
                    next_r.st = T_QUEUED;
                    next_r.ptype = d;
                    next_r.attn = ~(8'h01 << r.owner);
                end
            end
        end
        // queued format starts; active format counts down
        if (r.st == T_QUEUED && !link.cmd_valid) begin
            next_r.st = T_RUN;
            next_r.cnt = 32'(FMT_CYCLES);
        end
        if (r.st == T_RUN) begin
            if (fmt_abort_i) begin
                next_r.st = T_IDLE;
                next_r.degraded = 1'b1;
                next_r = answer(next_r, ST_CHECK, `FMT_SK_NOT_READY,
                                `FMT_ASC_IN_PROG);
            end else if (r.cnt == 32'h1) begin
                next_r.st = T_IDLE;
                next_r.degraded = 1'b0;
                next_r.protection_enabled_flag = (r.ptype != 2'h0);
                next_r.stored = (r.ptype != 2'h0)
                    ? block_size_i + `FMT_PI_BYTES : block_size_i;
                next_r.ref_tag = r.lba;
                next_r.ref_valid = (r.ptype == 2'h1);
                next_r = answer(next_r, ST_GOOD, 4'h0, 16'h0);
            end else begin
                next_r.cnt = r.cnt - 32'h1;
            end
        end
        // incoming commands
        if (link.cmd_valid) begin
            if (link.cmd_op == OP_SENSE && r.st == T_RUN) begin
                next_r = answer(next_r, ST_GOOD, `FMT_SK_NOT_READY,
                                `FMT_ASC_IN_PROG);
            end else if (link.cmd_op == OP_SENSE
                         || link.cmd_op == OP_INQUIRY) begin
                next_r = answer(next_r, ST_GOOD, 4'h0, 16'h0);
            end else if (r.st == T_RUN) begin
                next_r = answer(next_r, ST_CHECK, `FMT_SK_NOT_READY,
                                `FMT_ASC_IN_PROG);
            end else if (r.st == T_QUEUED || r.st == T_HDR) begin
                next_r = answer(next_r,
                    queue_disable_flag_i ? ST_BUSY : ST_FULL,
                    4'h0, 16'h0);
            end else if (link.cmd_op == OP_FORMAT) begin
                next_r.owner = link.cmd_init;
                next_r.sel = link.cmd_sel;
                next_r.lba = link.cmd_lba;
                next_r.hcnt = 4'h0;
                next_r.hlong = link.cmd_long;
                if (link.cmd_sel == `FMT_SEL_BAD) begin
                    next_r = answer(next_r, ST_CHECK, `FMT_SK_ILLEGAL,
                                    `FMT_ASC_BAD_CDB);
                end else if (link.cmd_list) begin
                    next_r.st = T_HDR;
                end else begin
                    d = decode(link.cmd_sel, `FMT_USAGE_ZERO);
                    next_r.ptype = d;
                    next_r.st = T_QUEUED;
                    next_r.attn = ~(8'h01 << link.cmd_init);
                end
            end else if ((link.cmd_op == OP_READ
                          || link.cmd_op == OP_WRITE) && r.degraded) begin
                next_r = answer(next_r, ST_CHECK, `FMT_SK_NOT_READY,
                                `FMT_ASC_IN_PROG);
            end else begin
                next_r = answer(next_r, ST_GOOD, 4'h0, 16'h0);
            end
        end
        if (busy && !link.cmd_valid && r.st == T_QUEUED) begin
            next_r.attn = r.attn;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // outputs straight from state, pi fill from a constant
    assign link.rsp_valid = r.rsp_valid;
    assign link.rsp_status = r.rsp_status;
    assign link.rsp_key = r.rsp_key;
    assign link.rsp_asc = r.rsp_asc;
    assign link.attn_mask = r.attn;
    assign fmt_active_o = (r.st == T_RUN);
    assign fmt_queued_o = (r.st == T_QUEUED);
    assign degraded_o = r.degraded;
    assign protection_enabled_flag_o = r.protection_enabled_flag;
    assign prot_type_o = r.ptype;
    assign stored_block_o = r.stored; // data, guard, app, ref tag
    assign pi_fill_o = `FMT_PI_FILL;
    assign ref_tag_o = r.ref_tag;
    assign ref_tag_valid_o = r.ref_valid;
endmodule : fmt_target
`default_nettype wire

// >>> sim/fmt_link_props.sv
// assertions on the command link between initiator and target
`include "fmt_cfg.svh"
`default_nettype none
module fmt_link_props
    import fmt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command side
    input wire logic cmd_valid,
    input wire opcode_e cmd_op,
    input wire logic [2:0] cmd_init,
    input wire logic cmd_list,
    input wire logic cmd_long,
    input wire logic [1:0] cmd_sel,
    input wire logic dout_valid,
    input wire logic [7:0] dout_data,
    input wire logic dout_last,
    // answer side
    input wire logic rsp_valid,
    input wire status_e rsp_status,
    input wire logic [3:0] rsp_key,
    input wire logic [15:0] rsp_asc,
    input wire logic [7:0] attn_mask
);
    logic pend, open, lng;
    logic [1:0] sel;
    logic [2:0] use_q, who;
    logic [3:0] cnt;
    // track the pending format and its header bytes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend <= 1'b0;
            open <= 1'b0;
            lng <= 1'b0;
            sel <= 2'h0;
            use_q <= 3'h0;
            who <= 3'h0;
            cnt <= 4'h0;
        end else begin
            if (cmd_valid && cmd_op == OP_FORMAT) begin
                pend <= 1'b1;
                open <= cmd_list;
                lng <= cmd_long;
                sel <= cmd_sel;
                use_q <= 3'h0;
                who <= cmd_init;
                cnt <= 4'h0;
            end else if (rsp_valid) begin
                pend <= 1'b0;
            end
            if (dout_valid) begin
                cnt <= cnt + 4'h1;
                if (cnt == 4'h0) begin
                    use_q <= dout_data[2:0];
                end
                if (dout_last) begin
                    open <= 1'b0;
                end
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_list_only: assert property (dout_valid |-> open)
        else $error("header byte with no list");
    a_hdr_length: assert property (dout_valid && dout_last |->
        cnt == (lng ? `FMT_LONG_HDR_LEN : `FMT_SHORT_HDR_LEN) - 4'h1)
        else $error("header length wrong");
    a_hdr_reserved: assert property (dout_valid && cnt == 4'h0
        |-> dout_data[7:3] == 5'h0) else $error("reserved bits set");
    a_bad_cdb: assert property (rsp_valid && pend && sel == 2'h1
        |-> rsp_status == ST_CHECK && rsp_key == `FMT_SK_ILLEGAL
        && rsp_asc == `FMT_ASC_BAD_CDB) else $error("selector 01h");
    a_type3_refused: assert property (rsp_valid && pend
        && sel == 2'h3 && use_q == 3'h1 |-> rsp_status == ST_CHECK
        && rsp_asc == `FMT_ASC_BAD_LIST) else $error("type 3 taken");
    a_bad_pair: assert property (rsp_valid && pend && sel != 2'h1
        && use_q != 3'h0 |-> rsp_status == ST_CHECK
        && rsp_key == `FMT_SK_ILLEGAL) else $error("bad pair taken");
    a_good_format: assert property (rsp_valid && pend
        && sel != 2'h1 && use_q == 3'h0 |-> rsp_status == ST_GOOD)
        else $error("valid format refused");
    a_attn_others: assert property (rsp_valid && pend
        && rsp_status == ST_GOOD |-> attn_mask == ~(8'h01 << who))
        else $error("attention mask wrong");
    // main scenarios
    c_type1: cover property (rsp_valid && pend && sel == 2'h2
        && rsp_status == ST_GOOD);
    c_type3: cover property (rsp_valid && pend && use_q == 3'h1);
    c_long: cover property (dout_last && lng);
endmodule : fmt_link_props
`default_nettype wire

// >>> sim/format_unit_command_handler_test.sv
// self-checking bench for both ends of the format command link
`include "fmt_cfg.svh"
`default_nettype none
module format_unit_command_handler_test
    import fmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic full;
        logic [2:0] st;
        logic [3:0] key;
        logic [15:0] asc;
    } note_s;
    localparam note_s GOOD = '{1'b0, ST_GOOD, 4'h0, 16'h0};
    localparam note_s CHK = '{1'b0, ST_CHECK, 4'h0, 16'h0};
    localparam note_s ACT = '{1'b1, ST_CHECK, 4'h2, 16'h0404};
    localparam note_s SNS = '{1'b1, ST_GOOD, 4'h2, 16'h0404};
    localparam note_s CDB = '{1'b1, ST_CHECK, 4'h5, 16'h2400};
    localparam note_s LST = '{1'b1, ST_CHECK, 4'h5, 16'h2600};
    localparam note_s BSY = '{1'b0, ST_BUSY, 4'h0, 16'h0};
    localparam note_s FUL = '{1'b0, ST_FULL, 4'h0, 16'h0};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic req = 1'b0;
    opcode_e op = OP_OTHER;
    logic [2:0] init = 3'h0;
    logic lst = 1'b0;
    logic lng = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [2:0] use_v = 3'h0;
    logic [31:0] lba = 32'h0;
    logic qd = 1'b0;
    logic abort_b = 1'b0;
    logic [7:0] opts = 8'h00;
    logic [15:0] bs_a = 16'h1000;
    logic ini_busy, ini_done, act_b;
    logic [2:0] ini_stat;
    logic [2:0] exp_done = 3'h0;
    logic pe_a, pe_b, deg_b, rtv;
    logic [1:0] pt_a;
    logic [7:0] fill_a;
    logic [15:0] blk_a, blk_b;
    logic [31:0] rtag, exp_lba;
    int errors = 0;
    int checks_done = 0;
    note_s qa[$];
    note_s qb[$];
    fmt_if a();
    fmt_if b();
    fmt_initiator fmt_initiator_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .link(a), .req_i(req), .op_i(op), .init_id_i(init), .list_i(lst),
        .long_i(lng), .sel_i(sel), .usage_i(use_v), .opts_i(opts),
        .lba_i(lba), .busy_o(ini_busy), .done_o(ini_done),
        .status_o(ini_stat));
    fmt_target #(.FMT_CYCLES(16)) fmt_target_i (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(ce), .link(a), .queue_disable_flag_i(qd),
        .block_size_i(bs_a), .fmt_abort_i(1'b0), .fmt_active_o(),
        .fmt_queued_o(), .degraded_o(), .protection_enabled_flag_o(pe_a),
        .prot_type_o(pt_a), .stored_block_o(blk_a), .pi_fill_o(fill_a),
        .ref_tag_o(rtag), .ref_tag_valid_o(rtv));
    fmt_target #(.FMT_CYCLES(16)) fmt_target_b_i (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(ce), .link(b), .queue_disable_flag_i(qd),
        .block_size_i(16'h0200), .fmt_abort_i(abort_b), .fmt_active_o(act_b),
        .fmt_queued_o(), .degraded_o(deg_b), .protection_enabled_flag_o(pe_b),
        .prot_type_o(), .stored_block_o(blk_b), .pi_fill_o(), .ref_tag_o(),
        .ref_tag_valid_o());
    fmt_link_props fmt_link_props_i (.clk_i(clk_i), .rst_i(rst_i),
        .cmd_valid(a.cmd_valid), .cmd_op(a.cmd_op), .cmd_init(a.cmd_init),
        .cmd_list(a.cmd_list), .cmd_long(a.cmd_long), .cmd_sel(a.cmd_sel),
        .dout_valid(a.dout_valid), .dout_data(a.dout_data),
        .dout_last(a.dout_last), .rsp_valid(a.rsp_valid),
        .rsp_status(a.rsp_status), .rsp_key(a.rsp_key),
        .rsp_asc(a.rsp_asc), .attn_mask(a.attn_mask));
    // 20 mhz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(ref note_s q[$], input logic [2:0] st,
        input logic [3:0] k, input logic [15:0] c);
        note_s n;
        if (q.size() == 0) begin
            check(32'h1, 32'h0);
            return;
        end
        n = q.pop_front();
        check(st, n.st);
        if (n.full) begin
            check({k, c}, {n.key, n.asc});
        end
    endtask : cmp
    // answer monitor pops the oldest note
    always @(posedge clk_i) begin
        if (a.rsp_valid) begin
            if (qa.size() > 0) begin
                exp_done <= qa[0].st;
            end
            cmp(qa, a.rsp_status, a.rsp_key, a.rsp_asc);
        end
        if (ini_done) begin
            check(ini_stat, exp_done);
        end
        if (b.rsp_valid) begin
            cmp(qb, b.rsp_status, b.rsp_key, b.rsp_asc);
        end
        if (rtv) begin
            check(rtag, exp_lba);
        end
    end
    task automatic settle();
        int i;
        for (i = 0; i < 400 && qa.size() + qb.size() > 0; i++) begin
            @(posedge clk_i);
        end
        if (i == 400) begin
            errors++;
            finish_test();
        end
        repeat (3) @(posedge clk_i);
    endtask : settle
    task automatic req_a(input opcode_e o, input logic [1:0] s,
        input logic [2:0] u);
        logic l;
        note_s n;
        l = (u != 3'h0) || 1'($urandom);
        n = (s == 2'h1) ? CDB : (u == 3'h0) ? GOOD : LST;
        n = (o == OP_FORMAT) ? n : GOOD;
        @(posedge clk_i);
        req <= 1'b1;
        op <= o;
        init <= 3'($urandom);
        lst <= l;
        lng <= 1'($urandom);
        sel <= s;
        use_v <= u;
        lba <= $urandom;
        opts <= 8'($urandom);
        bs_a <= 16'(($urandom % 8) + 1) << 9;
        qa.push_back(n);
        @(posedge clk_i);
        req <= 1'b0;
        exp_lba = lba;
        settle();
        check(ini_busy, 1'b0);
        if (o == OP_FORMAT && n.st == ST_GOOD) begin
            check(pe_a, s != 2'h0);
            check(pt_a, (s == 2'h0) ? 2'h0 : s - 2'h1);
            check(blk_a, (s == 2'h0) ? bs_a : bs_a + 16'h0008);
            check(fill_a, 8'hff);
        end
    endtask : req_a
    task automatic cmd_b(input opcode_e o, input logic push, input note_s n);
        @(posedge clk_i);
        b.cmd_valid <= 1'b1;
        b.cmd_op <= o;
        b.cmd_init <= 3'h3;
        if (push) begin
            qb.push_back(n);
        end
    endtask : cmd_b
    task automatic idle_b(input int k);
        @(posedge clk_i);
        b.cmd_valid <= 1'b0;
        repeat (k - 1) @(posedge clk_i);
    endtask : idle_b
    // main sequence
    initial begin
        b.cmd_valid = 1'b0;
        b.cmd_op = OP_OTHER;
        b.cmd_init = 3'h0;
        b.cmd_list = 1'b0;
        b.cmd_long = 1'b0;
        b.cmd_sel = 2'h0;
        b.cmd_lba = 32'h0;
        b.dout_valid = 1'b0;
        b.dout_data = 8'h00;
        b.dout_last = 1'b0;
        void'($urandom(40186));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        req_a(OP_INQUIRY, 2'h0, 3'h0);
        for (int s = 0; s < 4; s++) begin
            for (int u = 0; u < 3; u++) begin
                req_a(OP_FORMAT, 2'(s), 3'(u));
            end
        end
        for (int r = 0; r < 2; r++) begin
            qd <= r[0];
            cmd_b(OP_FORMAT, 1'b0, GOOD);
            cmd_b(OP_OTHER, 1'b1, r[0] ? BSY : FUL);
            idle_b(3);
            cmd_b(OP_OTHER, 1'b1, ACT);
            cmd_b(OP_SENSE, 1'b1, SNS);
            cmd_b(OP_INQUIRY, 1'b1, GOOD);
            idle_b(2);
            check(act_b, 1'b1);
            qb.push_back(CHK);
            abort_b <= 1'b1;
            @(posedge clk_i);
            abort_b <= 1'b0;
            settle();
            check(deg_b, 1'b1);
            cmd_b(OP_READ, 1'b1, CHK);
            cmd_b(OP_WRITE, 1'b1, CHK);
            idle_b(1);
            settle();
        end
        cmd_b(OP_FORMAT, 1'b1, GOOD);
        idle_b(1);
        settle();
        check(deg_b, 1'b0);
        check(b.attn_mask, 8'hf7);
        check(pe_b, 1'b0);
        check(blk_b, 16'h0200);
        cmd_b(OP_READ, 1'b1, GOOD);
        idle_b(1);
        settle();
        finish_test();
    end
endmodule : format_unit_command_handler_test
`default_nettype wire
